// [include/retry_pkg.sv]
// Package for the fault restart retry controller
package retry_pkg;
  localparam logic [2:0] RETRY_CNT_5 = 3'h5;
  localparam logic [2:0] RETRY_CNT_6 = 3'h6;
  localparam logic [2:0] RETRY_CNT_CONT = 3'h7;
  localparam logic [3:0] ATTEMPTS_5 = 4'h5;
  localparam logic [3:0] ATTEMPTS_6 = 4'h6;
  localparam int DELAY_UNIT_NS = 1000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int UNIT_CYCLES_INT = (DELAY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 24;
  localparam logic [TIMER_W-1:0] UNIT_CYCLES = TIMER_W'(UNIT_CYCLES_INT);
  localparam logic [3:0] ATTEMPT_RESET = 4'h0;

  typedef enum {
    ST_RUN,
    ST_WAIT,
    ST_RESTART,
    ST_LATCHED
  } retry_state_t;

  typedef struct packed {
    logic [2:0] retry_count;
    logic [2:0] retry_time;
    logic [7:0] delay_unit;
  } retry_cfg_t;
endpackage : retry_pkg

// [rtl/fault_restart_retry_control.sv]
// Fault restart retry controller
`timescale 1ns/10ps
`default_nettype none
module fault_restart_retry_control
  import retry_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  // Configuration
  input wire retry_cfg_t i_cfg,
  // Fault and on/off inputs
  input wire logic i_fault,
  input wire logic i_other_fault,
  input wire logic i_fault_clear,
  input wire logic i_on_cmd,
  input wire logic i_bias_ok,
  // Outputs
  output logic o_output_en,
  output logic o_restart_pulse,
  output logic o_latched_off,
  output logic [3:0] o_attempts
);
  retry_state_t state_ff;
  logic [3:0] attempts_ff;
  logic timer_start_ff;
  logic timer_done;
  logic [3:0] limit;
  logic unlimited;
  logic enabled;
  logic attempt_left;

  assign enabled = i_on_cmd && i_bias_ok;

  // Lower count codes allow no attempt at all
  always_comb
  begin
    unlimited = 1'b0;
    limit = ATTEMPT_RESET;
    case (i_cfg.retry_count)
      RETRY_CNT_5:
      begin
        limit = ATTEMPTS_5;
      end
      RETRY_CNT_6:
      begin
        limit = ATTEMPTS_6;
      end
      RETRY_CNT_CONT:
      begin
        unlimited = 1'b1;
      end
      default:
      begin
        limit = ATTEMPT_RESET;
      end
    endcase
  end

  assign attempt_left = unlimited || (attempts_ff < limit);

  retry_timer u_timer (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_start(timer_start_ff),
    .i_mult(i_cfg.retry_time),
    .i_unit(i_cfg.delay_unit),
    .o_done(timer_done)
  );

  // Sequencing of run, wait, restart and latch-off
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_ff <= ST_RUN;
    end
    else
    begin
      case (state_ff)
        ST_RUN:
        begin
          if (i_fault && enabled)
          begin
            if (attempt_left)
            begin
              state_ff <= ST_WAIT;
            end
            else
            begin
              state_ff <= ST_LATCHED;
            end
          end
        end
        ST_WAIT:
        begin
          // Off command, bias loss or a hard fault ends retrying
          if (!enabled || i_other_fault)
          begin
            state_ff <= ST_LATCHED;
          end
          else if (timer_done)
          begin
            state_ff <= ST_RESTART;
          end
        end
        ST_RESTART:
        begin
          state_ff <= ST_RUN;
        end
        ST_LATCHED:
        begin
          if (i_fault_clear)
          begin
            state_ff <= ST_RUN;
          end
        end
        default:
        begin
          state_ff <= ST_RUN;
        end
      endcase
    end
  end

  // Attempt counter; outside ST_RESTART a clear with the fault gone gives a fresh budget
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      attempts_ff <= ATTEMPT_RESET;
    end
    else if (state_ff == ST_RESTART)
    begin
      // Saturate so continuous mode cannot wrap the counter
      if (attempts_ff != 4'hf)
      begin
        attempts_ff <= attempts_ff + 4'h1;
      end
    end
    else if (i_fault_clear && (state_ff == ST_LATCHED || !i_fault))
    begin
      attempts_ff <= ATTEMPT_RESET;
    end
  end

  // Timer kick on each accepted fault
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      timer_start_ff <= 1'b0;
    end
    else
    begin
      timer_start_ff <= (state_ff == ST_RUN) && i_fault && enabled && attempt_left;
    end
  end

  // One pulse per restart attempt
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_restart_pulse <= 1'b0;
    end
    else
    begin
      o_restart_pulse <= (state_ff == ST_RESTART);
    end
  end

  // Output only runs while no fault is present
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_output_en <= 1'b0;
    end
    else
    begin
      o_output_en <= (state_ff == ST_RUN) && enabled && !i_fault;
    end
  end

  // Latch-off status
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_latched_off <= 1'b0;
    end
    else
    begin
      o_latched_off <= (state_ff == ST_LATCHED);
    end
  end

  // Attempt count, lagging the counter by one cycle like the status
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_attempts <= ATTEMPT_RESET;
    end
    else
    begin
      o_attempts <= attempts_ff;
    end
  end
endmodule : fault_restart_retry_control
`default_nettype wire

// [rtl/retry_timer.sv]
// Interval timer counting retry_time multiples of the fault's delay unit
`timescale 1ns/10ps
`default_nettype none
module retry_timer
  import retry_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  // Control
  input wire logic i_start,
  input wire logic [2:0] i_mult,
  input wire logic [7:0] i_unit,
  // Status
  output logic o_done
);
  logic [TIMER_W-1:0] cnt_ff;
  logic [TIMER_W-1:0] nxt_cnt;
  logic busy_ff;

  always_comb
  begin
    // Zero multiplier still gives one cycle of spacing
    nxt_cnt = TIMER_W'({5'h00, i_mult} * {8'h00, i_unit}) * UNIT_CYCLES;
    if (nxt_cnt == TIMER_W'(0))
    begin
      nxt_cnt = TIMER_W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_start)
      begin
        cnt_ff <= nxt_cnt;
        busy_ff <= 1'b1;
      end
      else if (busy_ff)
      begin
        if (cnt_ff == TIMER_W'(1))
        begin
          busy_ff <= 1'b0;
          o_done <= 1'b1;
        end
        cnt_ff <= cnt_ff - TIMER_W'(1);
      end
    end
  end
endmodule : retry_timer
`default_nettype wire

// [sim/fault_restart_retry_control_tb.sv]
// Bench for the retry controller
`timescale 1ns/10ps
`default_nettype none
module fault_restart_retry_control_tb;
  import retry_pkg::*;
  logic i_clk = 1'b0, i_resetn = 1'b0, i_other_fault = 1'b0, i_fault_clear = 1'b0;
  logic i_on_cmd = 1'b1, i_bias_ok = 1'b1, i_short = 1'b0, prev = 1'b0;
  logic i_fault, o_output_en, o_restart_pulse, o_latched_off;
  logic [3:0] o_attempts;
  retry_cfg_t i_cfg = 14'h0101;
  logic [3:0] exp_q[$];
  int num_errors = 0, checked = 0;
  always #4 i_clk = ~i_clk;
  fault_restart_retry_control fault_restart_retry_control_i (.*);
  load_model load_model_i (.*);
  task automatic chk(input logic ok);
    checked++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("MISMATCH %0t wrong output", $time);
    end
  endtask : chk
  task automatic give_verdict();
    $display("errors %0d checked %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  always @(posedge i_clk)
  begin
    prev <= o_latched_off;
    if (o_latched_off === 1'b1 && prev === 1'b0)
      chk(exp_q.size() > 0 && o_attempts === exp_q.pop_front());
  end
  // Continuous mode is stopped mid-wait after 8 attempts by off command, other fault or bias loss
  task automatic run(input logic [2:0] code, input logic [3:0] n, input int stop);
    int k = 0, p = 0, d = 0;
    i_cfg.retry_count <= code;
    i_cfg.retry_time <= 3'($urandom_range(2, 1));
    i_short <= 1'b1;
    exp_q.push_back(n);
    while (o_latched_off !== 1'b1 && k < 4000)
    begin
      @(posedge i_clk);
      k++;
      p += int'(o_restart_pulse === 1'b1);
      d += int'(p == 8);
      if (d == 20)
      begin
        i_on_cmd <= (stop != 0);
        i_other_fault <= (stop == 1);
        i_bias_ok <= (stop != 2);
      end
    end
    chk(o_output_en === 1'b0);
    i_short <= 1'b0;
    i_on_cmd <= 1'b1;
    i_other_fault <= 1'b0;
    i_bias_ok <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk(o_latched_off === 1'b1);
    i_fault_clear <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_fault_clear <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk(o_latched_off === 1'b0 && o_attempts === ATTEMPT_RESET);
  endtask : run
  initial
  begin
    void'($urandom(32'h0000_c02a));
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    run(RETRY_CNT_5, ATTEMPTS_5, 0);
    run(RETRY_CNT_6, ATTEMPTS_6, 0);
    run(RETRY_CNT_CONT, 4'h8, 0);
    run(RETRY_CNT_CONT, 4'h8, 1);
    run(RETRY_CNT_CONT, 4'h8, 2);
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge i_clk);
    chk(1'b0);
    give_verdict();
  end
endmodule : fault_restart_retry_control_tb
bind fault_restart_retry_control retry_monitor retry_monitor_i (.*);
`default_nettype wire

// [sim/load_model.sv]
// Shorted load model
`timescale 1ns/10ps
`default_nettype none
module load_model (
  input wire logic i_clk,
  input wire logic i_short,
  input wire logic o_output_en,
  output logic i_fault
);
  // Fault seen once the output drives into the short, kept while shorted
  always_ff @(posedge i_clk)
    i_fault <= i_short && (o_output_en || i_fault);
endmodule : load_model
`default_nettype wire

// [sim/retry_monitor.sv]
// Port checker for the retry controller
`timescale 1ns/10ps
`default_nettype none
module retry_monitor
  import retry_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire retry_cfg_t i_cfg,
  input wire logic i_fault,
  input wire logic i_other_fault,
  input wire logic i_fault_clear,
  input wire logic i_on_cmd,
  input wire logic i_bias_ok,
  input wire logic o_output_en,
  input wire logic o_restart_pulse,
  input wire logic o_latched_off,
  input wire logic [3:0] o_attempts
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // Starts saturated so the first attempt passes
  logic [9:0] gap_ff;
  always_ff @(posedge i_clk or negedge i_resetn)
    if (!i_resetn)
      gap_ff <= '1;
    else
      gap_ff <= o_restart_pulse ? '0 : gap_ff + 10'(!(&gap_ff));
  sequence s_lat; $rose(o_latched_off); endsequence
  sequence s_clr; i_fault_clear && !i_fault; endsequence
  property p_five; s_lat ##0 (i_cfg.retry_count == RETRY_CNT_5) |-> o_attempts == ATTEMPTS_5; endproperty
  a_five: assert property (p_five) else $error("count 5");
  property p_six; s_lat ##0 (i_cfg.retry_count == RETRY_CNT_6) |-> o_attempts == ATTEMPTS_6; endproperty
  a_six: assert property (p_six) else $error("count 6");
  property p_hold; o_latched_off && !i_fault_clear |=> o_latched_off && !o_output_en; endproperty
  a_hold: assert property (p_hold) else $error("latch lost");
  property p_cont; i_cfg.retry_count == RETRY_CNT_CONT && i_on_cmd && i_bias_ok && !i_other_fault
    && !o_latched_off |=> !o_latched_off; endproperty
  a_cont: assert property (p_cont) else $error("continuous");
  property p_gap; o_restart_pulse |-> (gap_ff >= 10'h07c) ##1 !o_restart_pulse; endproperty
  a_gap: assert property (p_gap) else $error("spacing");
  property p_clr; s_clr |-> ##[1:2] o_attempts == ATTEMPT_RESET; endproperty
  a_clr: assert property (p_clr) else $error("count kept");
endmodule : retry_monitor
`default_nettype wire
